//--- ureq_pkg.sv
// Shared constants and types for the USB redriver equalizer control bank.
package ureq_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_DS_EQ = 8'h20;
  localparam logic [7:0] ADDR_US_EQ = 8'h21;
  localparam logic [7:0] ADDR_LINK = 8'h22;

  localparam logic [7:0] RST_GEN_CTRL = 8'h00;
  localparam logic [7:0] RST_DS_EQ = 8'h00;
  localparam logic [3:0] RST_US_EQ = 4'h0;
  localparam logic [7:0] RST_LINK = 8'h00;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int EQ_W = 4;
  localparam int OVR_BIT = 4;
  localparam int CM_BIT = 7;
  localparam int LFPS_APPLY_EQUALIZER_BIT = 6;
  localparam int DEB_BIT = 5;
  localparam int DET_OFF_BIT = 4;
  localparam int INTV_LSB = 2;
  localparam int CMP_LSB = 0;

  localparam logic [1:0] CMP_FSM = 2'h0;
  localparam logic [1:0] CMP_DFP = 2'h1;
  localparam logic [1:0] CMP_UFP = 2'h2;
  localparam logic [1:0] CMP_OFF = 2'h3;
  localparam logic [1:0] INTV_8MS = 2'h0;
  localparam logic [1:0] INTV_12MS = 2'h1;

  // ----------------------------------------------------------------------
  // Timing at the 10 MHz core clock
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEB_US = 200;
  localparam int DEB_CYC = (DEB_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int DEB_W = 12;
  localparam logic [DEB_W-1:0] DEB_CNT = DEB_W'(DEB_CYC);
  localparam int DET8_MS = 8;
  localparam int DET12_MS = 12;
  localparam int DET8_CYC = DET8_MS * (CLK_HZ / 1000);
  localparam int DET12_CYC = DET12_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ureq_reg_req_t;

  typedef struct packed {
    logic [EQ_W-1:0] rx2;
    logic [EQ_W-1:0] rx1;
    logic [EQ_W-1:0] up;
  } ureq_eq_set_t;

endpackage

//--- ureq_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
`default_nettype none
module ureq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // The agreement check filters single-cycle disagreement on
  // slow multi-level strap inputs.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule
`default_nettype wire

//--- ureq_i2c_slave.sv
// I2C target that turns bus transfers into register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ureq_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side
  output ureq_pkg::ureq_reg_req_t req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} ureq_i2c_st_t;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_PTR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  localparam logic [3:0] BITS = 4'h8;

  ureq_i2c_st_t state;
  logic [1:0] pins;
  logic [1:0] prev;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [1:0] phase;
  logic rw;

  ureq_sync #(.W(2)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d({scl_in, sda_in}),
    .q(pins)
  );

  wire scl = pins[1];
  wire sda = pins[0];
  wire start = scl & prev[1] & prev[0] & !sda;
  wire stop = scl & prev[1] & !prev[0] & sda;
  wire rise = scl & !prev[1];
  wire fall = !scl & prev[1];
  wire byte_end = fall & (cnt == BITS);

  assign rd_addr = ptr;

  // A repeated start keeps the pointer so a write of the pointer may be
  // followed by a read of the same register.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= S_IDLE;
      prev <= 2'h3;
      cnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 8'h00;
      phase <= PH_ADDR;
      rw <= 1'h0;
      sda_oe <= 1'h0;
      req <= '0;
    end else begin
      prev <= pins;
      req.wr <= 1'h0;
      if (start) begin
        state <= S_RX;
        cnt <= 4'h0;
        phase <= PH_ADDR;
        sda_oe <= 1'h0;
      end else if (stop) begin
        state <= S_IDLE;
        sda_oe <= 1'h0;
      end else begin
        case (state)
          S_RX: begin
            if (rise) begin
              sh <= {sh[6:0], sda};
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              if (phase != PH_ADDR || sh[7:1] == DEV_ADDR) begin
                sda_oe <= 1'h1;
                state <= S_ACK;
              end else begin
                state <= S_IDLE;
              end
              if (phase == PH_ADDR) begin
                rw <= sh[0];
              end
              if (phase == PH_PTR) begin
                ptr <= sh;
              end
              if (phase == PH_DATA) begin
                req.wr <= 1'h1;
                req.addr <= ptr;
                req.data <= sh;
                ptr <= ptr + 8'h01;
              end
            end
          end
          S_ACK: begin
            if (fall) begin
              cnt <= 4'h0;
              if (rw) begin
                sh <= rd_data;
                sda_oe <= ~rd_data[7];
                state <= S_TX;
              end else begin
                sda_oe <= 1'h0;
                state <= S_RX;
                phase <= (phase == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          S_TX: begin
            if (rise) begin
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              sda_oe <= 1'h0;
              ptr <= ptr + 8'h01;
              state <= S_RACK;
            end else if (fall) begin
              sh <= {sh[6:0], 1'h0};
              sda_oe <= ~sh[6];
            end
          end
          S_RACK: begin
            if (rise && sda) begin
              state <= S_IDLE;
            end else if (fall) begin
              cnt <= 4'h0;
              sh <= rd_data;
              sda_oe <= ~rd_data[7];
              state <= S_TX;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- ureq_link_ctrl.sv
// Equalizer, LFPS, receiver detect and compliance control bank.
//
// Behaviour
// - Override clear: downstream fields show strap values.
// - Override set: written downstream levels are applied.
// - Override clear: upstream field shows strap value.
// - Override set: written upstream level is applied.
// - Status bit shows compliance mode, zero after reset.
// - LFPS bit zero forces equalizer zero during LFPS.
// - Debounce bit demands 200us LFPS before exit.
// - Detect-off bit suppresses receiver detect in U2/U3.
// - Interval code picks 8 ms or 12 ms detect.
// - Codes 01/10/11 force downstream, upstream, disable.
// - Code 00 lets link state machine decide.
// - Upstream and link registers reset to zero.
// - Sixteen levels, four-bit code per receiver.
`timescale 1ns/1ps
`default_nettype none
module ureq_link_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h12,
  parameter int DET8_CYC = ureq_pkg::DET8_CYC,
  parameter int DET12_CYC = ureq_pkg::DET12_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap pins, two four-level pins each
  input wire logic [3:0] downstream_equalizer_straps,
  input wire logic [3:0] upstream_equalizer_straps,
  // Link events
  input wire logic lfps_detect,
  input wire logic link_in_low_power,
  input wire logic fsm_compliance_dfp,
  input wire logic fsm_compliance_ufp,
  // Link controls
  output ureq_pkg::ureq_eq_set_t eq_applied,
  output logic low_power_exit,
  output logic rx_detect_start,
  output logic compliance_dfp,
  output logic compliance_ufp,
  output logic compliance_active_flag
);

  localparam int TW = $clog2(DET12_CYC + 1);
  localparam logic [TW-1:0] LAST8 = TW'(DET8_CYC - 1);
  localparam logic [TW-1:0] LAST12 = TW'(DET12_CYC - 1);
  localparam int EW = ureq_pkg::EQ_W;

  // ----------------------------------------------------------------------
  // Register access and pin sampling
  // ----------------------------------------------------------------------
  ureq_pkg::ureq_reg_req_t req;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] ds_strap;
  logic [3:0] us_strap;
  logic lfps;

  ureq_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .core_clk(core_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .req(req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  ureq_sync #(.W(9)) u_pins (
    .core_clk(core_clk),
    .resetn(resetn),
    .d({lfps_detect, downstream_equalizer_straps,
        upstream_equalizer_straps}),
    .q({lfps, ds_strap, us_strap})
  );

  assign sda_out = 1'h0;

  // ----------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------
  logic equalizer_software_override;
  logic [EW-1:0] rx2_level_select;
  logic [EW-1:0] rx1_level_select;
  logic [EW-1:0] upstream_rx_level_select;
  logic lfps_apply_equalizer;
  logic low_power_exit_debounce;
  logic low_power_detect_off;
  logic [1:0] downstream_detect_interval;
  logic [1:0] compliance_mode_select;

  wire wr_gen = req.wr && req.addr == ureq_pkg::ADDR_GEN_CTRL;
  wire wr_ds = req.wr && req.addr == ureq_pkg::ADDR_DS_EQ;
  wire wr_us = req.wr && req.addr == ureq_pkg::ADDR_US_EQ;
  wire wr_link = req.wr && req.addr == ureq_pkg::ADDR_LINK;

  // Fields track the straps while the override is clear, so setting the
  // override keeps the level in force until software writes a new one.
  wire [7:0] next_ds = !equalizer_software_override ? {ds_strap, ds_strap}
                     : wr_ds ? req.data
                     : {rx2_level_select, rx1_level_select};
  wire [EW-1:0] next_us = !equalizer_software_override ? us_strap
                        : wr_us ? req.data[EW-1:0]
                        : upstream_rx_level_select;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      equalizer_software_override <= ureq_pkg::RST_GEN_CTRL[ureq_pkg::OVR_BIT];
      {rx2_level_select, rx1_level_select} <= ureq_pkg::RST_DS_EQ;
      upstream_rx_level_select <= ureq_pkg::RST_US_EQ;
      {lfps_apply_equalizer, low_power_exit_debounce, low_power_detect_off,
       downstream_detect_interval, compliance_mode_select}
        <= ureq_pkg::RST_LINK[6:0];
    end else begin
      {rx2_level_select, rx1_level_select} <= next_ds;
      upstream_rx_level_select <= next_us;
      if (wr_gen) begin
        equalizer_software_override <= req.data[ureq_pkg::OVR_BIT];
      end
      if (wr_link) begin
        lfps_apply_equalizer <= req.data[ureq_pkg::LFPS_APPLY_EQUALIZER_BIT];
        low_power_exit_debounce <= req.data[ureq_pkg::DEB_BIT];
        low_power_detect_off <= req.data[ureq_pkg::DET_OFF_BIT];
        downstream_detect_interval <= req.data[ureq_pkg::INTV_LSB +: 2];
        compliance_mode_select <= req.data[ureq_pkg::CMP_LSB +: 2];
      end
    end
  end

  // Unmapped offsets and reserved bits read as zero.
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ureq_pkg::ADDR_GEN_CTRL: v[ureq_pkg::OVR_BIT] =
        equalizer_software_override;
      ureq_pkg::ADDR_DS_EQ: v = {rx2_level_select, rx1_level_select};
      ureq_pkg::ADDR_US_EQ: v[EW-1:0] = upstream_rx_level_select;
      ureq_pkg::ADDR_LINK: v = {compliance_active_flag, lfps_apply_equalizer,
        low_power_exit_debounce, low_power_detect_off,
        downstream_detect_interval, compliance_mode_select};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // A process rather than a continuous assignment, so that the read value
  // follows a register that changes while the pointer stays put.
  always_comb begin
    rd_data = read_reg(rd_addr);
  end

  // ----------------------------------------------------------------------
  // Equalizer application
  // ----------------------------------------------------------------------
  ureq_pkg::ureq_eq_set_t sel;
  assign sel = {rx2_level_select, rx1_level_select,
                upstream_rx_level_select};
  wire lfps_zero = lfps && !lfps_apply_equalizer;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      eq_applied <= '0;
    end else begin
      eq_applied <= lfps_zero ? '0 : sel;
    end
  end

  // ----------------------------------------------------------------------
  // LFPS exit from U2/U3
  // ----------------------------------------------------------------------
  logic [ureq_pkg::DEB_W-1:0] lfps_cnt;
  logic exit_sent;
  wire lfps_lp = lfps && link_in_low_power;
  wire deb_met = lfps_cnt >= ureq_pkg::DEB_CNT;
  wire exit_ok = lfps_lp && !exit_sent
                 && (!low_power_exit_debounce || deb_met);

  // One exit request per LFPS burst; the burst must drop before another.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lfps_cnt <= '0;
      exit_sent <= 1'h0;
      low_power_exit <= 1'h0;
    end else begin
      if (!lfps_lp) begin
        lfps_cnt <= '0;
      end else if (!deb_met) begin
        lfps_cnt <= lfps_cnt + 1'h1;
      end
      exit_sent <= lfps_lp && (exit_sent || exit_ok);
      low_power_exit <= exit_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver detect timer
  // ----------------------------------------------------------------------
  logic [TW-1:0] det_cnt;
  // Reserved interval codes fall back to the shorter interval.
  wire [TW-1:0] det_last =
    (downstream_detect_interval == ureq_pkg::INTV_12MS) ? LAST12
                                                        : LAST8;
  // A new interval code restarts the count, so a count already past the
  // new end never cuts the first interval short.
  wire intv_new = wr_link
    && req.data[ureq_pkg::INTV_LSB +: 2] != downstream_detect_interval;
  wire det_wrap = det_cnt >= det_last;
  wire det_mute = link_in_low_power && low_power_detect_off;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      det_cnt <= '0;
      rx_detect_start <= 1'h0;
    end else begin
      det_cnt <= (det_wrap || intv_new) ? '0 : det_cnt + 1'h1;
      rx_detect_start <= det_wrap && !det_mute;
    end
  end

  // ----------------------------------------------------------------------
  // Compliance mode
  // ----------------------------------------------------------------------
  wire next_dfp = compliance_mode_select == ureq_pkg::CMP_DFP
    || (compliance_mode_select == ureq_pkg::CMP_FSM
        && fsm_compliance_dfp);
  wire next_ufp = compliance_mode_select == ureq_pkg::CMP_UFP
    || (compliance_mode_select == ureq_pkg::CMP_FSM
        && fsm_compliance_ufp);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      compliance_dfp <= 1'h0;
      compliance_ufp <= 1'h0;
      compliance_active_flag <= 1'h0;
    end else begin
      compliance_dfp <= next_dfp;
      compliance_ufp <= next_ufp;
      compliance_active_flag <= next_dfp || next_ufp;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_ds_strap;
    !equalizer_software_override |=>
      {rx2_level_select, rx1_level_select} == {2{$past(ds_strap)}};
  endproperty
  a_ds_strap: assert property (p_ds_strap) else $error("ds strap lost");

  property p_ds_write;
    equalizer_software_override && wr_ds ##1 !lfps_zero |=>
      eq_applied.rx1 == $past(req.data[3:0], 2)
      && eq_applied.rx2 == $past(req.data[7:4], 2);
  endproperty
  a_ds_write: assert property (p_ds_write) else $error("ds write lost");

  property p_us_strap;
    !equalizer_software_override |=>
      upstream_rx_level_select == $past(us_strap);
  endproperty
  a_us_strap: assert property (p_us_strap) else $error("us strap lost");

  property p_us_write;
    equalizer_software_override && wr_us ##1 !lfps_zero |=>
      eq_applied.up == $past(req.data[3:0], 2);
  endproperty
  a_us_write: assert property (p_us_write) else $error("us write lost");

  property p_cm_off;
    compliance_mode_select == ureq_pkg::CMP_OFF [*2] |->
      !compliance_active_flag && !compliance_dfp && !compliance_ufp;
  endproperty
  a_cm_off: assert property (p_cm_off) else $error("compliance not off");

  property p_lfps_zero;
    lfps_zero |=> eq_applied == '0;
  endproperty
  a_lfps_zero: assert property (p_lfps_zero) else $error("eq not zeroed");

  property p_debounce;
    low_power_exit |-> !$past(low_power_exit_debounce)
      || $past(lfps_cnt) >= ureq_pkg::DEB_CNT;
  endproperty
  a_debounce: assert property (p_debounce) else $error("early exit");

  property p_det_mute;
    rx_detect_start |-> !$past(det_mute);
  endproperty
  a_det_mute: assert property (p_det_mute) else $error("detect not muted");

  property p_det_period;
    rx_detect_start |-> $past(det_cnt) == $past(det_last);
  endproperty
  a_det_period: assert property (p_det_period) else $error("bad interval");

  property p_cm_dfp;
    compliance_mode_select == ureq_pkg::CMP_DFP [*2] |->
      compliance_dfp && !compliance_ufp && compliance_active_flag;
  endproperty
  a_cm_dfp: assert property (p_cm_dfp) else $error("dfp not forced");

  property p_cm_fsm;
    compliance_mode_select == ureq_pkg::CMP_FSM [*2] |->
      compliance_ufp == $past(fsm_compliance_ufp);
  endproperty
  a_cm_fsm: assert property (p_cm_fsm) else $error("fsm not followed");

  property p_reset_zero;
    $rose(resetn) |-> upstream_rx_level_select == ureq_pkg::RST_US_EQ
      && {compliance_active_flag, lfps_apply_equalizer,
          low_power_exit_debounce, low_power_detect_off,
          downstream_detect_interval, compliance_mode_select}
         == ureq_pkg::RST_LINK;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("bad reset");

endmodule
`default_nettype wire

//--- ureq_link_partner.sv
// Link partner model that sends LFPS bursts and holds the link in U2/U3.
`timescale 1ns/1ps
`default_nettype none
module ureq_link_partner (
  // Clock
  input wire logic core_clk,
  // Commands from the bench
  input wire logic burst_go,
  input wire logic [15:0] burst_len,
  input wire logic low_power,
  // Link events
  output logic lfps_detect,
  output logic link_in_low_power
);
  logic [15:0] left = 16'h0000;

  // Squelch shows no LFPS between bursts, so the detect line idles low.
  always_ff @(posedge core_clk) begin
    if (burst_go) begin
      left <= burst_len;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end

  assign lfps_detect = (left != 16'h0000);
  assign link_in_low_power = low_power;
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the redriver equalizer control bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, resetn, m_scl, m_sda, sda_oe, sda_o;
  logic [3:0] ds_str, us_str;
  logic fsm_dfp, fsm_ufp, go, lp, lfps, in_lp;
  logic [15:0] blen;
  logic lp_exit, det, cdfp, cufp, cflag;
  logic [7:0] v;
  logic [1:0] cm_exp [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
  ureq_pkg::ureq_eq_set_t eq;
  wire logic sda_line = m_sda & (sda_o | ~sda_oe);
  int fail_count = 0, samples_checked = 0, cyc = 0, n0 = 0, g = 0;
  int det_last = 0, det_gap = 0, det_n = 0, exit_n = 0, exit_at = 0;

  ureq_link_ctrl #(.DET8_CYC(40), .DET12_CYC(60)) ureq_link_ctrl_inst (
    .core_clk(core_clk), .resetn(resetn), .scl_in(m_scl),
    .sda_in(sda_line), .sda_out(sda_o), .sda_oe(sda_oe),
    .downstream_equalizer_straps(ds_str),
    .upstream_equalizer_straps(us_str), .lfps_detect(lfps),
    .link_in_low_power(in_lp), .fsm_compliance_dfp(fsm_dfp),
    .fsm_compliance_ufp(fsm_ufp), .eq_applied(eq),
    .low_power_exit(lp_exit), .rx_detect_start(det),
    .compliance_dfp(cdfp), .compliance_ufp(cufp),
    .compliance_active_flag(cflag)
  );

  ureq_link_partner ureq_link_partner_inst (
    .core_clk(core_clk), .burst_go(go), .burst_len(blen),
    .low_power(lp), .lfps_detect(lfps), .link_in_low_power(in_lp)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pulse bookkeeping; gaps and times are in core clock cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (det) begin
      det_gap <= cyc - det_last;
      det_last <= cyc;
      det_n <= det_n + 1;
    end
    if (lp_exit) begin
      exit_n <= exit_n + 1;
      exit_at <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // Report, check, timing, bus and burst tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  // SDA moves two cycles after SCL falls so the synchroniser never
  // sees both pins change together and mistakes it for a start.
  task automatic clk_bit(input logic b, output logic s);
    m_sda = b;
    tick(8);
    m_scl = 1'b1;
    tick(5);
    s = sda_line;
    tick(5);
    m_scl = 1'b0;
    tick(2);
  endtask

  task automatic start();
    m_sda = 1'b1;
    tick(5);
    m_scl = 1'b1;
    tick(5);
    m_sda = 1'b0;
    tick(5);
    m_scl = 1'b0;
    tick(5);
  endtask

  task automatic stop();
    m_sda = 1'b0;
    tick(5);
    m_scl = 1'b1;
    tick(5);
    m_sda = 1'b1;
    tick(5);
  endtask

  task automatic byte_out(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    check({11'h000, s}, 12'h000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    byte_out(8'h24);
    byte_out(a);
    byte_out(d);
    stop();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic s;
    start();
    byte_out(8'h24);
    byte_out(a);
    start();
    byte_out(8'h25);
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'b1, s);
      v = {v[6:0], s};
    end
    clk_bit(1'b1, s);
    stop();
    check({4'h0, v}, {4'h0, exp});
  endtask

  task automatic burst(input logic [15:0] n);
    blen = n;
    go = 1'b1;
    g = cyc;
    n0 = exit_n;
    tick(1);
    go = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {m_scl, m_sda, go, lp, fsm_dfp, fsm_ufp} = 6'h30;
    ds_str = 4'h5;
    us_str = 4'h9;
    blen = 16'h0000;
    tick(8);
    resetn = 1'b1;
    tick(8);
    rd_chk(8'h20, 8'h55);
    rd_chk(8'h21, 8'h09);
    rd_chk(8'h22, 8'h00);
    rd_chk(8'h30, 8'h00);
    check(eq, 12'h559);
    wr(8'h20, 8'hA3);
    rd_chk(8'h20, 8'h55);
    wr(8'h0A, 8'h10);
    wr(8'h20, 8'hA3);
    wr(8'h21, 8'hFC);
    ds_str = 4'h7;
    us_str = 4'h2;
    tick(8);
    rd_chk(8'h20, 8'hA3);
    rd_chk(8'h21, 8'h0C);
    check(eq, 12'hA3C);
    wr(8'h0A, 8'h00);
    tick(8);
    rd_chk(8'h20, 8'h77);
    rd_chk(8'h21, 8'h02);
    check(eq, 12'h772);
    fsm_dfp = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, {6'h3C, 2'(c)});
      check({cdfp, cufp}, cm_exp[c]);
      check(cflag, |cm_exp[c]);
      rd_chk(8'h22, {|cm_exp[c], 5'h1C, 2'(c)});
    end
    fsm_dfp = 1'b0;
    wr(8'h0A, 8'h10);
    wr(8'h22, 8'h00);
    lp = 1'b1;
    burst(16'd40);
    tick(15);
    check(eq, 12'h000);
    tick(40);
    check(exit_n - n0, 1);
    wr(8'h22, 8'h40);
    burst(16'd40);
    tick(15);
    check(eq, 12'h772);
    wr(8'h22, 8'h20);
    burst(16'd1000);
    tick(1100);
    check(exit_n - n0, 0);
    burst(16'd2100);
    tick(2200);
    check(exit_n - n0, 1);
    check(exit_at - g >= 2000 && exit_at - g <= 2010, 1);
    wr(8'h22, 8'h04);
    tick(130);
    check(det_gap, 60);
    wr(8'h22, 8'h00);
    tick(100);
    check(det_gap, 40);
    wr(8'h22, 8'h08);
    tick(100);
    check(det_gap, 40);
    wr(8'h22, 8'h10);
    n0 = det_n;
    tick(200);
    check(det_n - n0, 0);
    lp = 1'b0;
    tick(100);
    check(det_n - n0 > 1, 1);
    final_report();
  end

  // A hang ends the run as a mismatch.
  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
